// [common/cbs_regs.svh]
`ifndef CBS_REGS_SVH
`define CBS_REGS_SVH

// Synchroniser width and bit positions of the asynchronous sideband inputs
`define CBS_SYNC_W 5
`define CBS_SYNC_IGNORE_NE 0
`define CBS_SYNC_SOFT_INIT 1
`define CBS_SYNC_BUS_INIT 2
`define CBS_SYNC_LINT_LO 3
`define CBS_SYNC_LINT_HI 4

// Synchroniser flops per input
`define CBS_SYNC_STAGES 2

// Bus clocks allowed from reset seen to all bus outputs released
`define CBS_RESET_QUIET_CLKS 2

// Reset values
`define CBS_LIC_ENABLE_RST 1'b1
`define CBS_PIN_IDLE 1'b1

`endif

// [common/cbs_pkg.sv]
package cbs_pkg;

    // Reset, self-test and soft-initialise sequencing
    typedef enum logic [1:0] {
        st_reset = 2'b00,
        st_builtin_self_test = 2'b01,
        st_run = 2'b10,
        st_init = 2'b11
    } cbs_state_t;

    // Snoop result driver
    typedef enum logic [1:0] {
        snp_idle = 2'b00,
        snp_stall = 2'b01,
        snp_gap = 2'b10,
        snp_result = 2'b11
    } cbs_snp_t;

endpackage : cbs_pkg

// [verilog/cbs_sync.sv]
`timescale 1ns/1ns
`include "cbs_regs.svh"

module cbs_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`CBS_SYNC_W-1:0] async_n,
    output logic [`CBS_SYNC_W-1:0] sync_n
);

    ////////////////////////////////////////////////////////////////////////////////
    // Two flops per bit; the first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < `CBS_SYNC_W; i = i + 1) begin : g_bit
            logic meta_reg;
            logic meta_next;
            logic stable_reg;
            logic stable_next;
            always_comb begin
                meta_next = async_n[i];
                stable_next = meta_reg;
            end
            // Reset to the inactive (high) level so nothing fires at release
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    meta_reg <= `CBS_PIN_IDLE;
                    stable_reg <= `CBS_PIN_IDLE;
                end else begin
                    meta_reg <= meta_next;
                    stable_reg <= stable_next;
                end
            end
            assign sync_n[i] = stable_reg;
        end
    endgenerate

endmodule : cbs_sync

// [verilog/cbs_snoop.sv]
`timescale 1ns/1ns
`include "cbs_regs.svh"

module cbs_snoop
    import cbs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic snoop_req,
    input wire logic snoop_stall,
    input wire logic snoop_hit,
    input wire logic snoop_snoop_hit_modified,
    input wire logic hit_n_in,
    input wire logic snoop_hit_modified_n_in,
    output logic hit_n_out,
    output logic hit_oe,
    output logic snoop_hit_modified_n_out,
    output logic snoop_hit_modified_oe,
    output logic snoop_done,
    output logic peer_stall
);

    cbs_snp_t st_reg;
    cbs_snp_t st_next;
    logic hit_drv_reg;
    logic hit_drv_next;
    logic snoop_hit_modified_drv_reg;
    logic snoop_hit_modified_drv_next;
    logic done_reg;
    logic done_next;
    logic peer_reg;
    logic peer_next;
    logic hit_n_reg;
    logic hit_n_next;
    logic snoop_hit_modified_n_reg;
    logic snoop_hit_modified_n_next;

    ////////////////////////////////////////////////////////////////////////////////
    // Stall is both lines low together; a gap cycle lets the pair be asserted again
    always_comb begin
        st_next = st_reg;
        hit_drv_next = 1'b0;
        snoop_hit_modified_drv_next = 1'b0;
        done_next = 1'b0;
        case (st_reg)
            snp_idle: begin
                if (snoop_req) begin
                    st_next = snoop_stall ? snp_stall : snp_result;
                    hit_drv_next = snoop_stall ? 1'b1 : snoop_hit;
                    snoop_hit_modified_drv_next = snoop_stall ? 1'b1 : snoop_snoop_hit_modified;
                    done_next = !snoop_stall;
                end
            end
            snp_stall: begin
                st_next = snp_gap;
            end
            snp_gap: begin
                st_next = snp_result;
                hit_drv_next = snoop_stall ? 1'b1 : snoop_hit;
                snoop_hit_modified_drv_next = snoop_stall ? 1'b1 : snoop_snoop_hit_modified;
                done_next = !snoop_stall;
                if (snoop_stall) begin
                    st_next = snp_stall;
                end
            end
            snp_result: begin
                st_next = snp_idle;
            end
            default: begin
                st_next = snp_idle;
            end
        endcase
        // Only a pair low while we are not driving hit ourselves counts as the peer stalling
        peer_next = !hit_n_in && !snoop_hit_modified_n_in && !hit_drv_reg;
        // Pin levels get their own flops so the outputs carry no gate after a register
        hit_n_next = !hit_drv_next;
        snoop_hit_modified_n_next = !snoop_hit_modified_drv_next;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= snp_idle;
            hit_drv_reg <= 1'b0;
            snoop_hit_modified_drv_reg <= 1'b0;
            done_reg <= 1'b0;
            peer_reg <= 1'b0;
            hit_n_reg <= `CBS_PIN_IDLE;
            snoop_hit_modified_n_reg <= `CBS_PIN_IDLE;
        end else begin
            st_reg <= st_next;
            hit_drv_reg <= hit_drv_next;
            snoop_hit_modified_drv_reg <= snoop_hit_modified_drv_next;
            done_reg <= done_next;
            peer_reg <= peer_next;
            hit_n_reg <= hit_n_next;
            snoop_hit_modified_n_reg <= snoop_hit_modified_n_next;
        end
    end

    // Open-drain: drive low only while enabled
    assign hit_n_out = hit_n_reg;
    assign hit_oe = hit_drv_reg;
    assign snoop_hit_modified_n_out = snoop_hit_modified_n_reg;
    assign snoop_hit_modified_oe = snoop_hit_modified_drv_reg;
    assign snoop_done = done_reg;
    assign peer_stall = peer_reg;

    a_stall_pair: assert property (@(posedge clk) disable iff (!rst_n)
        (st_reg == snp_stall) |-> (hit_oe && snoop_hit_modified_oe))
        else $error("snoop stall without both lines driven");

endmodule : cbs_snoop

// [verilog/cbs_sideband.sv]
`timescale 1ns/1ns
`include "cbs_regs.svh"


module cbs_sideband
    import cbs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ignore_numeric_error_in_n,
    input wire logic soft_init_n,
    input wire logic bus_initialize_n,
    input wire logic [1:0] local_interrupt_pins_n,
    input wire logic hit_n_in,
    output logic hit_n_out,
    output logic hit_oe,
    input wire logic snoop_hit_modified_n_in,
    output logic snoop_hit_modified_n_out,
    output logic snoop_hit_modified_oe,
    output logic bus_lock_n_out,
    output logic bus_lock_oe,
    output logic internal_error_out_n,
    input wire logic internal_error_det,
    output logic shutdown_req,
    input wire logic fp_error_det,
    input wire logic fp_noncontrol_issue,
    input wire logic numeric_error_enable,
    output logic fp_exception,
    output logic fp_continue,
    output logic int_reg_reset,
    output logic reset_vector_start,
    output logic builtin_self_test_start,
    input wire logic builtin_self_test_done,
    input wire logic snoop_req,
    input wire logic snoop_stall,
    input wire logic snoop_hit,
    input wire logic snoop_snoop_hit_modified,
    output logic snoop_done,
    output logic peer_stall,
    input wire logic lock_seq_begin,
    input wire logic lock_seq_end,
    input wire logic lic_cfg_wr,
    input wire logic lic_cfg_enable,
    output logic [1:0] lic_lint,
    output logic maskable_irq_request,
    output logic nmi_request
);

    localparam int QUIET_CLKS = `CBS_RESET_QUIET_CLKS;

    logic [`CBS_SYNC_W-1:0] sync_n;
    logic s_ignore;
    logic s_init;
    logic s_bus_initialize;
    logic [1:0] s_lint;

    cbs_state_t state_reg;
    cbs_state_t state_next;
    logic internal_error_out_n_reg;
    logic internal_error_out_n_next;
    logic shut_reg;
    logic shut_next;
    logic intrst_reg;
    logic intrst_next;
    logic rvec_reg;
    logic rvec_next;
    logic builtin_self_test_reg;
    logic builtin_self_test_next;
    logic pend_reg;
    logic pend_next;
    logic fpx_reg;
    logic fpx_next;
    logic fpc_reg;
    logic fpc_next;
    logic lock_reg;
    logic lock_next;
    logic lock_n_reg;
    logic lic_en_reg;
    logic lic_en_next;
    logic irq_reg;
    logic irq_next;
    logic nmi_reg;
    logic nmi_next;
    logic [1:0] lint_reg;
    logic [1:0] lint_next;

    ////////////////////////////////////////////////////////////////////////////////
    // Asynchronous sideband inputs pass a two-flop synchroniser before use, except the reset strap, which reads soft_init_n raw
    cbs_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_n({local_interrupt_pins_n, bus_initialize_n, soft_init_n,
                  ignore_numeric_error_in_n}),
        .sync_n(sync_n)
    );

    // Active-low pins turned into active-high levels
    assign s_ignore = !sync_n[`CBS_SYNC_IGNORE_NE];
    assign s_init = !sync_n[`CBS_SYNC_SOFT_INIT];
    assign s_bus_initialize = !sync_n[`CBS_SYNC_BUS_INIT];
    assign s_lint = ~sync_n[`CBS_SYNC_LINT_HI:`CBS_SYNC_LINT_LO];

    ////////////////////////////////////////////////////////////////////////////////
    // Snoop responder runs regardless of the sequencer state, so init never blocks it
    cbs_snoop u_snoop (
        .clk(clk),
        .rst_n(rst_n),
        .snoop_req(snoop_req),
        .snoop_stall(snoop_stall),
        .snoop_hit(snoop_hit),
        .snoop_snoop_hit_modified(snoop_snoop_hit_modified),
        .hit_n_in(hit_n_in),
        .snoop_hit_modified_n_in(snoop_hit_modified_n_in),
        .hit_n_out(hit_n_out),
        .hit_oe(hit_oe),
        .snoop_hit_modified_n_out(snoop_hit_modified_n_out),
        .snoop_hit_modified_oe(snoop_hit_modified_oe),
        .snoop_done(snoop_done),
        .peer_stall(peer_stall)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer: strap at reset release, self-test, soft init
    // The strap reads the raw pin in the first cycle after release, since the
    // synchroniser still holds its reset value then
    always_comb begin
        state_next = state_reg;
        intrst_next = 1'b0;
        rvec_next = 1'b0;
        builtin_self_test_next = 1'b0;
        case (state_reg)
            st_reset: begin
                if (!soft_init_n) begin
                    state_next = st_builtin_self_test;
                    builtin_self_test_next = 1'b1;
                end else begin
                    state_next = st_run;
                    rvec_next = 1'b1;
                end
            end
            st_builtin_self_test: begin
                if (builtin_self_test_done) begin
                    state_next = st_run;
                    rvec_next = 1'b1;
                end
            end
            st_run: begin
                if (s_init) begin
                    state_next = st_init;
                    intrst_next = 1'b1;
                end
            end
            st_init: begin
                if (!s_init) begin
                    state_next = st_run;
                    rvec_next = 1'b1;
                end
            end
            default: begin
                state_next = st_reset;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= st_reset;
            intrst_reg <= 1'b0;
            rvec_reg <= 1'b0;
            builtin_self_test_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            intrst_reg <= intrst_next;
            rvec_reg <= rvec_next;
            builtin_self_test_reg <= builtin_self_test_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Internal error latch and shutdown request; a new error beats a same-cycle clear
    always_comb begin
        internal_error_out_n_next = internal_error_out_n_reg;
        if (s_init || s_bus_initialize) begin
            internal_error_out_n_next = 1'b1;
        end
        if (internal_error_det) begin
            internal_error_out_n_next = 1'b0;
        end
        shut_next = internal_error_det && internal_error_out_n_reg;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            internal_error_out_n_reg <= `CBS_PIN_IDLE;
            shut_reg <= 1'b0;
        end else begin
            internal_error_out_n_reg <= internal_error_out_n_next;
            shut_reg <= shut_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Numeric error handling; in native mode the ignore pin is dead
    always_comb begin
        pend_next = pend_reg;
        fpx_next = 1'b0;
        fpc_next = 1'b0;
        if (fp_noncontrol_issue && pend_reg) begin
            if (!numeric_error_enable && s_ignore) begin
                fpc_next = 1'b1;
            end else begin
                fpx_next = 1'b1;
                pend_next = 1'b0;
            end
        end
        if (fp_error_det) begin
            pend_next = 1'b1;
        end
        // Soft init clears integer state only; the pending fp error survives
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend_reg <= 1'b0;
            fpx_reg <= 1'b0;
            fpc_reg <= 1'b0;
        end else begin
            pend_reg <= pend_next;
            fpx_reg <= fpx_next;
            fpc_reg <= fpc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus lock and local interrupt pin routing
    always_comb begin
        lock_next = lock_reg;
        if (lock_seq_end) begin
            lock_next = 1'b0;
        end
        if (lock_seq_begin) begin
            lock_next = 1'b1;
        end
        lic_en_next = lic_cfg_wr ? lic_cfg_enable : lic_en_reg;
        irq_next = !lic_en_reg && s_lint[0];
        nmi_next = !lic_en_reg && s_lint[1];
        lint_next = lic_en_reg ? s_lint : 2'h0;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lock_reg <= 1'b0;
            lock_n_reg <= `CBS_PIN_IDLE;
            lic_en_reg <= `CBS_LIC_ENABLE_RST;
            irq_reg <= 1'b0;
            nmi_reg <= 1'b0;
            lint_reg <= 2'h0;
        end else begin
            lock_reg <= lock_next;
            lock_n_reg <= !lock_next;
            lic_en_reg <= lic_en_next;
            irq_reg <= irq_next;
            nmi_reg <= nmi_next;
            lint_reg <= lint_next;
        end
    end

    assign internal_error_out_n = internal_error_out_n_reg;
    assign shutdown_req = shut_reg;
    assign fp_exception = fpx_reg;
    assign fp_continue = fpc_reg;
    assign int_reg_reset = intrst_reg;
    assign reset_vector_start = rvec_reg;
    assign builtin_self_test_start = builtin_self_test_reg;
    assign bus_lock_n_out = lock_n_reg;
    assign bus_lock_oe = lock_reg;
    assign maskable_irq_request = irq_reg;
    assign nmi_request = nmi_reg;
    assign lic_lint = lint_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    a_internal_error_out_sets: assert property (@(posedge clk) disable iff (!rst_n)
        internal_error_det |=> !internal_error_out_n)
        else $error("internal error not flagged");

    a_internal_error_out_holds: assert property (@(posedge clk) disable iff (!rst_n)
        (!internal_error_out_n && !s_init && !s_bus_initialize) |=> !internal_error_out_n)
        else $error("internal error dropped without a clear");

    a_shutdown_pair: assert property (@(posedge clk) disable iff (!rst_n)
        (internal_error_det && internal_error_out_n) |=> shutdown_req && !internal_error_out_n)
        else $error("no shutdown with new internal error");

    a_fp_ignore: assert property (@(posedge clk) disable iff (!rst_n)
        (fp_noncontrol_issue && pend_reg && s_ignore && !numeric_error_enable)
        |=> fp_continue && !fp_exception)
        else $error("ignored numeric error still faulted");

    a_ne_native: assert property (@(posedge clk) disable iff (!rst_n)
        (fp_noncontrol_issue && pend_reg && numeric_error_enable) |=> fp_exception)
        else $error("native mode did not fault");

    a_init_seq: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == st_run && s_init) |=> int_reg_reset ##1 (state_reg == st_init))
        else $error("soft init did not reset integer state");

    a_builtin_self_test_strap: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == st_reset && !soft_init_n) |=> builtin_self_test_start)
        else $error("self-test not started on strap");

    a_snoop_init: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == st_init && snoop_req && !snoop_stall && u_snoop.st_reg == snp_idle)
        |=> snoop_done)
        else $error("snoop not serviced during soft init");

    a_lint_route: assert property (@(posedge clk) disable iff (!rst_n)
        (!lic_en_reg && s_lint[1]) |=> nmi_request)
        else $error("pin 1 not routed as nmi");

    a_lic_reset: assert property (@(posedge clk)
        !rst_n |=> lic_en_reg)
        else $error("interrupt controller not enabled by reset");

    a_lock_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (bus_lock_oe && !lock_seq_end) |=> bus_lock_oe && !bus_lock_n_out)
        else $error("bus lock released early");

    a_reset_quiet: assert property (@(posedge clk)
        !rst_n |-> ##[1:QUIET_CLKS] (!bus_lock_oe && !hit_oe && !snoop_hit_modified_oe
        && internal_error_out_n))
        else $error("bus outputs still driven after reset");

endmodule : cbs_sideband

// [verif/cbs_chipset_model.sv]
`timescale 1ns/1ns

module cbs_chipset_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stall_cmd,
    input wire logic prio_want,
    input wire logic bus_lock_n,
    output logic stall_reg,
    output logic prio_req_reg,
    output logic prio_own_reg
);
    logic stall_next;
    logic prio_req_next;
    logic prio_own_next;

    ////////////////////////////////////////////////////////////////////////
    // Stall drives both snoop lines the cycle after stall_cmd, for as long as it is held; ownership waits on lock
    always_comb begin
        stall_next = stall_cmd;
        prio_req_next = prio_want;
        prio_own_next = prio_want & prio_req_reg & bus_lock_n;
        // Lines released in reset so the pull-ups take them high
        if (!rst_n) begin
            stall_next = 1'b0;
            prio_req_next = 1'b0;
            prio_own_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        stall_reg <= stall_next;
        prio_req_reg <= prio_req_next;
        prio_own_reg <= prio_own_next;
    end
endmodule : cbs_chipset_model

// [verif/tb_top.sv]
`timescale 1ns/1ns

module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ignore_numeric_error_in_n = 1'b1, soft_init_n = 1'b1, bus_initialize_n = 1'b1;
    logic [1:0] local_interrupt_pins_n = 2'h3;
    logic internal_error_det = 1'b0, fp_error_det = 1'b0, fp_noncontrol_issue = 1'b0;
    logic numeric_error_enable = 1'b0, builtin_self_test_done = 1'b0, snoop_req = 1'b0;
    logic snoop_stall = 1'b0, snoop_hit = 1'b0, snoop_snoop_hit_modified = 1'b0, lock_seq_begin = 1'b0;
    logic lock_seq_end = 1'b0, lic_cfg_wr = 1'b0, lic_cfg_enable = 1'b1;
    logic stall_cmd = 1'b0, prio_want = 1'b0;
    logic hit_n_out, hit_oe, snoop_hit_modified_n_out, snoop_hit_modified_oe;
    logic bus_lock_n_out, bus_lock_oe, internal_error_out_n, shutdown_req;
    logic fp_exception, fp_continue, int_reg_reset, reset_vector_start;
    logic builtin_self_test_start, snoop_done, peer_stall, maskable_irq_request;
    logic nmi_request, stall_reg, prio_own;
    logic [1:0] lic_lint;
    logic [31:0] seed = 32'h0003;
    int fail_count = 0;
    int check_count = 0;
    int i;

    ////////////////////////////////////////////////////////////////////////
    // Wired-AND lines with pull-ups: low while either agent drives low
    wire logic hit_n_in = ~((hit_oe & ~hit_n_out) | stall_reg);
    wire logic snoop_hit_modified_n_in = ~((snoop_hit_modified_oe & ~snoop_hit_modified_n_out)
        | stall_reg);
    wire logic bus_lock_n = ~(bus_lock_oe & ~bus_lock_n_out);
    wire logic [5:0] obs = {peer_stall, int_reg_reset, reset_vector_start,
        builtin_self_test_start, internal_error_out_n, fp_exception};

    always #5 clk = ~clk;

    cbs_sideband dut (
        .clk, .rst_n, .ignore_numeric_error_in_n, .soft_init_n, .bus_initialize_n,
        .local_interrupt_pins_n, .hit_n_in, .hit_n_out, .hit_oe, .snoop_hit_modified_n_in,
        .snoop_hit_modified_n_out, .snoop_hit_modified_oe, .bus_lock_n_out, .bus_lock_oe,
        .internal_error_out_n, .internal_error_det, .shutdown_req, .fp_error_det,
        .fp_noncontrol_issue, .numeric_error_enable, .fp_exception, .fp_continue,
        .int_reg_reset, .reset_vector_start, .builtin_self_test_start,
        .builtin_self_test_done, .snoop_req, .snoop_stall, .snoop_hit, .snoop_snoop_hit_modified,
        .snoop_done, .peer_stall, .lock_seq_begin, .lock_seq_end, .lic_cfg_wr,
        .lic_cfg_enable, .lic_lint, .maskable_irq_request, .nmi_request
    );

    cbs_chipset_model partner (
        .clk, .rst_n, .stall_cmd, .prio_want, .bus_lock_n, .stall_reg,
        .prio_req_reg(), .prio_own_reg(prio_own)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // Step past an edge and let its updates land before sampling
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick

    task automatic print_verdict;
        $display("Checks: %0d, mismatches: %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    // Bounded wait on one observed bit; running out ends the run
    task automatic wait_bit(input int b, input logic v, input int lim);
        int n = 0;
        while (obs[b] !== v && n < lim) begin
            tick;
            n++;
        end
        chk(8'(obs[b]), 8'(v));
        if (obs[b] !== v) begin
            print_verdict;
        end
    endtask : wait_bit

    // Snoop with n stall repeats; hit results are random
    task automatic snoop(input int n);
        logic h, m;
        seed = lfsr_next(seed);
        // Both lines together would read as a stall, so a result never has both
        h = seed[0] & ~seed[1];
        m = seed[1];
        snoop_req <= 1'b1;
        snoop_stall <= (n > 0);
        snoop_hit <= h;
        snoop_snoop_hit_modified <= m;
        for (int k = 0; k < n; k++) begin
            tick;
            snoop_req <= 1'b0;
            snoop_stall <= (k + 1 < n);
            chk(8'({hit_n_in, snoop_hit_modified_n_in, snoop_done}), 8'h0);
            tick;
            chk(8'({hit_n_in, snoop_hit_modified_n_in, snoop_done}), 8'h6);
        end
        tick;
        snoop_req <= 1'b0;
        chk(8'({hit_n_in, snoop_hit_modified_n_in, snoop_done}), 8'({~h, ~m, 1'b1}));
        tick;
    endtask : snoop

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) tick;
        chk(8'({hit_oe, snoop_hit_modified_oe, bus_lock_oe, internal_error_out_n}), 8'h1);
        rst_n <= 1'b1;
        wait_bit(3, 1'b1, 4);
        // Controller enabled out of reset: pins forwarded as local interrupts
        seed = lfsr_next(seed);
        local_interrupt_pins_n <= seed[1:0];
        repeat (4) tick;
        chk(8'({lic_lint, nmi_request, maskable_irq_request}), 8'({~seed[1:0], 2'b00}));
        lic_cfg_wr <= 1'b1;
        lic_cfg_enable <= 1'b0;
        tick;
        lic_cfg_wr <= 1'b0;
        for (i = 0; i < 4; i++) begin
            local_interrupt_pins_n <= i[1:0];
            repeat (4) tick;
            chk(8'({nmi_request, maskable_irq_request}), {6'h0, ~i[1:0]});
        end
        local_interrupt_pins_n <= 2'h3;
        for (i = 0; i < 6; i++) begin
            snoop(i % 3);
        end
        stall_cmd <= 1'b1;
        tick;
        stall_cmd <= 1'b0;
        wait_bit(5, 1'b1, 3);
        wait_bit(5, 1'b0, 4);
        // Internal error held until bus init clears it
        internal_error_det <= 1'b1;
        tick;
        internal_error_det <= 1'b0;
        chk(8'({internal_error_out_n, shutdown_req}), 8'h1);
        repeat (5) tick;
        chk(8'({internal_error_out_n, shutdown_req}), 8'h0);
        bus_initialize_n <= 1'b0;
        wait_bit(1, 1'b1, 5);
        bus_initialize_n <= 1'b1;
        // Numeric error: ignored, native mode, and not ignored; inputs settled early
        for (i = 0; i < 3; i++) begin
            ignore_numeric_error_in_n <= (i == 2);
            numeric_error_enable <= (i == 1);
            repeat (4) tick;
            fp_error_det <= 1'b1;
            tick;
            fp_error_det <= 1'b0;
            fp_noncontrol_issue <= 1'b1;
            tick;
            fp_noncontrol_issue <= 1'b0;
            chk(8'({fp_continue, fp_exception}), (i == 0) ? 8'h2 : 8'h1);
        end
        fp_noncontrol_issue <= 1'b1;
        tick;
        fp_noncontrol_issue <= 1'b0;
        chk(8'({fp_continue, fp_exception}), 8'h0);
        // Soft init clears the error and still answers snoops
        internal_error_det <= 1'b1;
        tick;
        internal_error_det <= 1'b0;
        soft_init_n <= 1'b0;
        wait_bit(4, 1'b1, 5);
        snoop(0);
        snoop(1);
        chk(8'(internal_error_out_n), 8'h1);
        soft_init_n <= 1'b1;
        wait_bit(3, 1'b1, 5);
        // Priority agent must wait out a locked sequence
        prio_want <= 1'b1;
        lock_seq_begin <= 1'b1;
        tick;
        lock_seq_begin <= 1'b0;
        snoop(0);
        repeat (3) tick;
        chk(8'({bus_lock_oe, bus_lock_n_out, prio_own}), 8'h4);
        lock_seq_end <= 1'b1;
        tick;
        lock_seq_end <= 1'b0;
        chk(8'({bus_lock_oe, bus_lock_n_out}), 8'h1);
        tick;
        chk(8'(prio_own), 8'h1);
        prio_want <= 1'b0;
        // Mid-run reset while locked and in error, self-test strap low
        lock_seq_begin <= 1'b1;
        internal_error_det <= 1'b1;
        tick;
        lock_seq_begin <= 1'b0;
        internal_error_det <= 1'b0;
        rst_n <= 1'b0;
        soft_init_n <= 1'b0;
        tick;
        tick;
        chk(8'({hit_oe, snoop_hit_modified_oe, bus_lock_oe, internal_error_out_n}), 8'h1);
        rst_n <= 1'b1;
        wait_bit(2, 1'b1, 4);
        soft_init_n <= 1'b1;
        repeat (4) tick;
        builtin_self_test_done <= 1'b1;
        tick;
        builtin_self_test_done <= 1'b0;
        wait_bit(3, 1'b1, 2);
        repeat (4) tick;
        print_verdict;
    end
endmodule : tb_top
